/* logic/rkt_pkg.sv */
// Summary of operation
// - Press needs four low samples 10 ms apart
// - Keys polled continually, never edge triggered
// - Confirmed press flags key, starts code send
// - Every frame carries a new rolling code
// - Nonlinear mixer with output feedback builds code
// - Thirteen config bytes, lockable against writes
// - Code block, key identity, sync from config
// - Forty mixer bits folded to 24 or 36
// - Sync pattern byte sent for receiver lock
// - Timer gives debounce tick and bit clock
// - Timer gives frame pause and hold limit
// - RF power enable low only while sending
// - Bits leave on one transmit pin
// - Lamp select picks lamp or RF enable on RF pin in crystal variant
// - RC variant uses oscillator pin as lamp
// - Reset initialises all device state
// - Lamp during pause, RF enable during frame
// - Repeat frames while held; halt after 80 s
// - Polarity bit sets transmit idle level
package rkt_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SAMPLE_MS       = 10;
  localparam int unsigned SAMPLE_CYCLES   = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned HOLD_LIMIT_S    = 80;
  localparam int unsigned HOLD_TICKS      = HOLD_LIMIT_S * 1000 / SAMPLE_MS;
  localparam logic [2:0]  PRESS_SAMPLES   = 3'h4;
  localparam int unsigned BIT_UNIT_CYCLES = 16;
  // Key and code widths
  localparam int unsigned NUM_KEYS  = 4;
  localparam int unsigned GEN_BITS  = 40;
  localparam int unsigned SYNC_BITS = 8;
  localparam int unsigned SHORT_LEN = 24;
  localparam int unsigned LONG_LEN  = 36;
  // Config memory layout
  localparam int unsigned CFG_BYTES   = 13;
  localparam logic [3:0]  A_KEY_ID0   = 4'h0;
  localparam logic [3:0]  A_SYNC      = 4'h3;
  localparam logic [3:0]  A_BLOCK0    = 4'h4;
  localparam logic [3:0]  A_OPTIONS   = 4'h7;
  localparam logic [3:0]  A_BIT_DIV   = 4'h8;
  localparam logic [3:0]  A_PAUSE     = 4'hA;
  localparam logic [3:0]  A_LOCK      = 4'hC;
  localparam logic [3:0]  A_STATUS    = 4'hD;
  localparam logic [3:0]  A_ROLL      = 4'hE;
  // Option bits
  localparam int unsigned OPT_POL     = 0;
  localparam int unsigned OPT_LAMPSEL = 1;
  localparam int unsigned OPT_HOLDEN  = 2;
  localparam int unsigned OPT_LONG    = 3;
  localparam int unsigned OPT_RC      = 4;
  localparam int unsigned OPT_PAUSEEN = 5;
  localparam int unsigned LOCK_BIT    = 7;
  // Reset values of config bytes
  localparam logic [7:0] RST_OPTIONS = 8'h30;
  localparam logic [7:0] RST_BIT_DIV = 8'h03;
  localparam logic [7:0] RST_PAUSE   = 8'h08;
  localparam logic [7:0] RST_OTHER   = 8'h00;
  // Controller states
  typedef enum logic [2:0] {S_IDLE, S_GEN, S_SEND, S_PAUSE, S_HALT} rkt_state_t;
endpackage

/* logic/rkt_top.sv */
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module rkt_top #(
  parameter int unsigned SAMPLE_CYC = rkt_pkg::SAMPLE_CYCLES,
  parameter int unsigned HOLD_TICK  = rkt_pkg::HOLD_TICKS
) (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  // Key switches, active low
  input  wire logic [rkt_pkg::NUM_KEYS-1:0] key_n_in,
  // Register port
  input  wire logic [3:0]                   reg_addr_in,
  input  wire logic [7:0]                   reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [7:0]                   reg_rdata_out,
  // Link pins
  output logic                              tx_out,
  output logic                              rf_power_or_lamp_pin_out,
  output logic                              osc_out_or_lamp_pin_out,
  output logic      [rkt_pkg::NUM_KEYS-1:0] key_pressed_out
);
  import rkt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Config memory and register port
  logic [7:0]       cfg_q [CFG_BYTES];       // Config bytes
  logic [7:0]       cfg_d [CFG_BYTES];
  logic [7:0]       rdata_q, rdata_d;        // Read data, one cycle late
  logic             locked;                  // Write disable in force
  rkt_state_t       state_q, state_d;
  logic [23:0]      roll_q, roll_d;          // Rolling counter

  assign locked = cfg_q[A_LOCK][LOCK_BIT];

  // Reset value per config byte
  function automatic logic [7:0] cfg_rst(input int unsigned idx);
    case (idx)
      A_OPTIONS: cfg_rst = RST_OPTIONS;
      A_BIT_DIV: cfg_rst = RST_BIT_DIV;
      A_PAUSE:   cfg_rst = RST_PAUSE;
      default:   cfg_rst = RST_OTHER;
    endcase
  endfunction

  // Writes land only while unlocked
  always_comb begin
    for (int i = 0; i < CFG_BYTES; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (reg_wr_in && !locked && reg_addr_in < A_STATUS) begin
      cfg_d[reg_addr_in] = reg_wdata_in;
    end
    rdata_d = 8'h00;
    if (reg_rd_in) begin
      if (reg_addr_in < A_STATUS) begin
        rdata_d = cfg_q[reg_addr_in];
      end else if (reg_addr_in == A_STATUS) begin
        rdata_d = {1'b0, state_q, key_pressed_out};
      end else if (reg_addr_in == A_ROLL) begin
        rdata_d = roll_q[7:0];
      end
    end
  end

  // Register config and read data
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg_q[i] <= cfg_rst(i);
      end
      rdata_q <= 8'h00;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Key synchroniser and debounce
  logic [NUM_KEYS-1:0] s1_q, s2_q, s3_q;      // Three-stage sampler
  logic [NUM_KEYS-1:0] filt_q, filt_d;        // Agreed key level
  logic [2:0]          low_q [NUM_KEYS];      // Consecutive low samples
  logic [2:0]          low_d [NUM_KEYS];
  logic [NUM_KEYS-1:0] press_q, press_d;      // Confirmed presses
  logic [31:0]         tick_cnt_q, tick_cnt_d;
  logic                tick_q, tick_d;        // 10 ms sample strobe

  // Sample tick and polled counts
  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h1;
    if (tick_cnt_q == SAMPLE_CYC - 1) begin
      tick_cnt_d = 32'h0;
      tick_d     = 1'b1;
    end
    filt_d = filt_q;
    for (int k = 0; k < NUM_KEYS; k++) begin
      if (s2_q[k] == s3_q[k]) begin
        filt_d[k] = s3_q[k];
      end
    end
    low_d   = low_q;
    press_d = press_q;
    for (int k = 0; k < NUM_KEYS; k++) begin
      if (tick_q) begin
        if (filt_q[k]) begin
          low_d[k]   = 3'h0;
          press_d[k] = 1'b0;
        end else if (low_q[k] < PRESS_SAMPLES) begin
          low_d[k] = low_q[k] + 3'h1;
          // Fourth uninterrupted low confirms
          if (low_q[k] == PRESS_SAMPLES - 3'h1) begin
            press_d[k] = 1'b1;
          end
        end
      end
    end
  end

  // Register debounce state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q       <= '1;
      s2_q       <= '1;
      s3_q       <= '1;
      filt_q     <= '1;
      press_q    <= '0;
      tick_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
      for (int k = 0; k < NUM_KEYS; k++) begin
        low_q[k] <= 3'h0;
      end
    end else begin
      s1_q       <= key_n_in;
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      filt_q     <= filt_d;
      press_q    <= press_d;
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
      low_q      <= low_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code generator and frame controller
  logic [GEN_BITS-1:0] gen_q, gen_d;          // Mixer state
  logic [5:0]          gcnt_q, gcnt_d;        // Mixer round count
  logic [43:0]         frame_q, frame_d;      // Sync plus code, MSB first
  logic [5:0]          bits_q, bits_d;        // Bits left in frame
  logic [15:0]         btim_q, btim_d;        // Bit and pause timer
  logic [13:0]         hold_q, hold_d;        // Hold time in ticks
  logic                any_key;
  logic                opt_long;
  logic [15:0]         bit_len;

  assign any_key  = |press_q;
  assign opt_long = cfg_q[A_OPTIONS][OPT_LONG];
  assign bit_len  = 16'((cfg_q[A_BIT_DIV] + 16'h1) * BIT_UNIT_CYCLES);

  // One nonlinear round; top bit returns as feedback
  function automatic logic [GEN_BITS-1:0] mix_round(input logic [GEN_BITS-1:0] s);
    logic nb;
    nb = s[39] ^ s[20] ^ (s[5] & s[13]) ^ (s[31] | s[2]) ^ (s[27] & ~s[17]);
    mix_round = {s[38:0], nb};
  endfunction

  // Frame sequencing
  always_comb begin
    state_d = state_q;
    gen_d   = gen_q;
    gcnt_d  = gcnt_q;
    frame_d = frame_q;
    bits_d  = bits_q;
    btim_d  = btim_q;
    roll_d  = roll_q;
    hold_d  = (state_q == S_IDLE) ? 14'h0 : hold_q;
    if (tick_q && any_key && state_q != S_IDLE && hold_q != 14'h3FFF) begin
      hold_d = hold_q + 14'h1;
    end
    case (state_q)
      S_IDLE: begin
        if (any_key) begin
          state_d = S_GEN;
        end
      end
      S_GEN: begin
        if (gcnt_q == 6'h0) begin
          // Seed from secrets and the rolling count
          roll_d = roll_q + 24'h1;
          gen_d  = {cfg_q[A_BLOCK0], cfg_q[A_BLOCK0+1], cfg_q[A_BLOCK0+2], 16'h0} ^
                   {16'h0, cfg_q[A_KEY_ID0], cfg_q[A_KEY_ID0+1], cfg_q[A_KEY_ID0+2]} ^
                   {roll_q, 16'hA5C3};
          gcnt_d = 6'h1;
        end else if (gcnt_q < 6'(GEN_BITS)) begin
          gen_d  = mix_round(gen_q);
          gcnt_d = gcnt_q + 6'h1;
        end else begin
          // Fold forty bits into the chosen code length
          frame_d = opt_long ?
            {cfg_q[A_SYNC], gen_q[35:0] ^ {gen_q[39:36], 32'h0}} :
            {cfg_q[A_SYNC], gen_q[23:0] ^ {gen_q[39:24], 8'h0}, 12'h0};
          bits_d  = opt_long ? 6'(SYNC_BITS + LONG_LEN) : 6'(SYNC_BITS + SHORT_LEN);
          btim_d  = 16'h0;
          gcnt_d  = 6'h0;
          state_d = S_SEND;
        end
      end
      S_SEND: begin
        if (btim_q == bit_len - 16'h1) begin
          btim_d  = 16'h0;
          frame_d = {frame_q[42:0], 1'b0};
          bits_d  = bits_q - 6'h1;
          if (bits_q == 6'h1) begin
            // Pause only when enabled, else next frame at once
            if (!any_key) begin
              state_d = S_IDLE;
            end else if (cfg_q[A_OPTIONS][OPT_PAUSEEN]) begin
              state_d = S_PAUSE;
            end else begin
              state_d = S_GEN;
            end
          end
        end else begin
          btim_d = btim_q + 16'h1;
        end
      end
      S_PAUSE: begin
        if (btim_q == 16'(cfg_q[A_PAUSE] * bit_len)) begin
          btim_d  = 16'h0;
          state_d = any_key ? S_GEN : S_IDLE;
        end else begin
          btim_d = btim_q + 16'h1;
        end
      end
      S_HALT: begin
        // Wait for every key to let go
        if (!any_key) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    // Hold limit overrides any frame in flight
    // Idle excluded: the count only clears on the edge after leaving halt
    if (cfg_q[A_OPTIONS][OPT_HOLDEN] && hold_q >= 14'(HOLD_TICK) && state_q != S_HALT && state_q != S_IDLE) begin
      state_d = S_HALT;
      gcnt_d  = 6'h0;
    end
  end

  // Register frame state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= S_IDLE;
      gen_q   <= '0;
      gcnt_q  <= 6'h0;
      frame_q <= '0;
      bits_q  <= 6'h0;
      btim_q  <= 16'h0;
      roll_q  <= 24'h0;
      hold_q  <= 14'h0;
    end else begin
      state_q <= state_d;
      gen_q   <= gen_d;
      gcnt_q  <= gcnt_d;
      frame_q <= frame_d;
      bits_q  <= bits_d;
      btim_q  <= btim_d;
      roll_q  <= roll_d;
      hold_q  <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pins, all registered
  logic                tx_q, tx_d;
  logic                rfp_q, rfp_d;
  logic                olp_q, olp_d;
  logic                osc_q;                 // Divided clock for oscillator pin
  logic                rf_power_enable_n_n, lamp_n;

  // Pin muxing per clock variant and lamp select
  always_comb begin
    rf_power_enable_n_n = (state_q != S_SEND);
    lamp_n = (state_q != S_PAUSE);
    // Idle rests at the polarity level; data bits pass as is
    tx_d = (state_q == S_SEND) ? frame_q[43] : cfg_q[A_OPTIONS][OPT_POL];
    if (cfg_q[A_OPTIONS][OPT_RC]) begin
      rfp_d = rf_power_enable_n_n;
      olp_d = lamp_n;
    end else begin
      rfp_d = cfg_q[A_OPTIONS][OPT_LAMPSEL] ? rf_power_enable_n_n : lamp_n;
      olp_d = osc_q;
    end
  end

  // Register pins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_q  <= 1'b0;
      rfp_q <= 1'b1;
      olp_q <= 1'b1;
      osc_q <= 1'b0;
      key_pressed_out <= '0;
    end else begin
      tx_q  <= tx_d;
      rfp_q <= rfp_d;
      olp_q <= olp_d;
      osc_q <= ~osc_q;
      key_pressed_out <= press_q;
    end
  end
  assign tx_out                   = tx_q;
  assign rf_power_or_lamp_pin_out = rfp_q;
  assign osc_out_or_lamp_pin_out  = olp_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence gen_start_s;
    state_q == S_GEN && gcnt_q == 6'h0;
  endsequence
  sequence gen_rounds_s;
    (state_q == S_GEN)[*8];
  endsequence

  chk_press_four: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(press_q[0]) |-> $past(tick_q) && $past(low_q[0]) == 3'h3)
    else $error("press confirmed without four low samples");
  chk_high_restart: assert property (@(posedge clk_in) disable iff (rst_in)
    tick_q && filt_q[1] |=> low_q[1] == 3'h0 && !press_q[1])
    else $error("high sample did not restart count");
  chk_roll_steps: assert property (@(posedge clk_in) disable iff (rst_in)
    gen_start_s |=> roll_q == $past(roll_q) + 24'h1)
    else $error("rolling count did not advance");
  chk_gen_rounds: assert property (@(posedge clk_in) disable iff (rst_in)
    gen_start_s |-> gen_rounds_s)
    else $error("mixer left early");
  chk_lock_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    locked && reg_wr_in && reg_addr_in == A_SYNC |=> $stable(cfg_q[A_SYNC]))
    else $error("locked config changed");
  chk_rf_send: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_q[A_OPTIONS][OPT_RC] && $past(cfg_q[A_OPTIONS][OPT_RC]) |->
      rf_power_or_lamp_pin_out == ($past(state_q) != S_SEND))
    else $error("rf enable outside frame");
  chk_lamp_pause: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == S_PAUSE && cfg_q[A_OPTIONS][OPT_RC] |=> !osc_out_or_lamp_pin_out)
    else $error("lamp dark in pause");
  chk_tx_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == S_IDLE ##1 state_q == S_IDLE |-> tx_out == $past(cfg_q[A_OPTIONS][OPT_POL], 1))
    else $error("idle transmit level wrong");
  chk_hold_halt: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_q[A_OPTIONS][OPT_HOLDEN] && hold_q >= 14'(HOLD_TICK) && state_q != S_HALT && state_q != S_IDLE
      |=> state_q == S_HALT)
    else $error("hold limit did not halt");
  chk_status_read: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == A_STATUS |=> reg_rdata_out[3:0] == $past(key_pressed_out))
    else $error("status read wrong");
endmodule

/* verif/rkt_link_model.sv */
`timescale 1ns/1ps
module rkt_link_model #(
  parameter int BIT_LEN = 16
) (
  // Clock
  input  wire logic       clk_in,
  // Transmitter stage side
  input  wire logic       tx_in,
  input  wire logic       rf_n_in,
  // Key switches, open contacts pulled up
  output logic      [3:0] key_n_out
);
  int          frame_cyc;  // Length of last low burst on the RF pin
  int          frame_n;    // Bits caught in that burst
  int          frame_cnt;  // Bursts seen so far
  logic [63:0] frame_bits; // Bits in arrival order, newest at bit 0

  ////////////////////////////////////////////////////////////////
  // Open switches sit high through the pull-ups
  initial begin
    key_n_out = 4'hF;
    frame_cnt = 0;
  end

  // Bouncy press: short low, a long high, then held low
  task automatic bounce(input int k, input int sc);
    key_n_out[k] <= 1'b0;
    repeat (2*sc-2) @(posedge clk_in);
    key_n_out[k] <= 1'b1; // Long enough for a tick to see it
    repeat (2*sc) @(posedge clk_in);
    key_n_out[k] <= 1'b0;
  endtask

  // Opening the switch returns the line to the pull-up level
  task automatic release_key(input int k);
    key_n_out[k] <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////
  // Receiver side: sample mid-bit while the RF stage is powered
  initial begin
    int          cyc;
    int          n;
    logic [63:0] bits;
    forever begin
      @(negedge rf_n_in);
      cyc  = 0;
      n    = 0;
      bits = '0;
      // Count only edges at which the pin is still seen low
      while (1'b1) begin
        @(posedge clk_in);
        if (rf_n_in !== 1'b0) break;
        cyc++;
        if (cyc % BIT_LEN == BIT_LEN/2) begin
          bits = {bits[62:0], tx_in};
          n++;
        end
      end
      frame_cyc  = cyc;
      frame_n    = n;
      frame_bits = bits;
      frame_cnt++;
    end
  end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import rkt_pkg::*;
  localparam int SC = 20; // Short sample interval keeps the run brief
  localparam int HT = 10;
  // Design inputs and outputs
  logic        clk_in       = 1'b0;
  logic        rst_in       = 1'b1;
  logic [3:0]  key_n_in;
  logic [3:0]  reg_addr_in  = 4'h0;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic [7:0]  reg_rdata_out;
  logic        tx_out;
  logic        rf_power_or_lamp_pin_out;
  logic        osc_out_or_lamp_pin_out;
  logic [3:0]  key_pressed_out;
  // Bench model state
  int          num_errors  = 0;
  int          check_count = 0;
  logic [7:0]  cfg [16];          // Expected config bytes
  logic [31:0] seed = 32'h0000_5679; // 22137
  logic [7:0]  d;
  logic [7:0]  opt;
  logic [43:0] code_a;
  logic [43:0] code_b;
  logic        o1;
  int          ln;

  ////////////////////////////////////////////////////////////////
  rkt_top #(.SAMPLE_CYC(SC), .HOLD_TICK(HT)) i_dut (
    .clk_in                   (clk_in),
    .rst_in                   (rst_in),
    .key_n_in                 (key_n_in),
    .reg_addr_in              (reg_addr_in),
    .reg_wdata_in             (reg_wdata_in),
    .reg_wr_in                (reg_wr_in),
    .reg_rd_in                (reg_rd_in),
    .reg_rdata_out            (reg_rdata_out),
    .tx_out                   (tx_out),
    .rf_power_or_lamp_pin_out (rf_power_or_lamp_pin_out),
    .osc_out_or_lamp_pin_out  (osc_out_or_lamp_pin_out),
    .key_pressed_out          (key_pressed_out)
  );

  rkt_link_model #(.BIT_LEN(16)) i_link (
    .clk_in    (clk_in),
    .tx_in     (tx_out),
    .rf_n_in   (rf_power_or_lamp_pin_out),
    .key_n_out (key_n_in)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Write: one strobe cycle; model follows the lock and map limits
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    if (a < 4'hD && cfg[12][7] == 1'b0) cfg[a] = v;
    @(posedge clk_in);
  endtask

  // Read: data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    v = reg_rdata_out;
    @(posedge clk_in);
  endtask

  task automatic check_map();
    for (int a = 0; a < 16; a++) begin
      rd(a, d);
      chk(d, cfg[a]);
    end
  endtask

  task automatic wait_cnt(input int target);
    int n;
    n = 0;
    while (i_link.frame_cnt < target && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    chk(i_link.frame_cnt >= target, 1);
  endtask

  // Bouncy press, then the press must land after four clean ticks
  task automatic press_chk(input int k);
    int n;
    n = 0;
    i_link.bounce(k, SC);
    while (key_pressed_out[k] !== 1'b1 && n < 5*SC) begin
      @(posedge clk_in);
      n++;
    end
    chk(n > 3*SC && n <= 4*SC+8, 1);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 16; i++) begin
      cfg[i] = (i == 7) ? RST_OPTIONS : (i == 8) ? RST_BIT_DIV : (i == 10) ? RST_PAUSE : RST_OTHER;
    end
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk({tx_out, rf_power_or_lamp_pin_out, osc_out_or_lamp_pin_out, key_pressed_out}, 7'h30);
    @(posedge clk_in);
    check_map();
    // Random identity, sync and code block; shortest bit period
    for (int a = 0; a < 7; a++) wr(a, rnd());
    wr(A_BIT_DIV, 8'h00);
    wr(A_PAUSE, 8'h04);
    wr(4'hD, 8'hFF); // Status is not writable
    wr(4'hF, 8'hFF); // Outside the map
    check_map();
    // Modes: RC 24-bit, RC 36-bit inverted, crystal lamp on RF pin, crystal RF
    for (int j = 0; j < 4; j++) begin
      opt = (j == 0) ? 8'h30 : (j == 1) ? 8'h39 : (j == 2) ? 8'h20 : 8'h22;
      ln  = opt[3] ? 36 : 24;
      wr(A_OPTIONS, opt);
      @(posedge clk_in); // Pin settles one edge after the new option
      chk(tx_out, opt[0]);
      press_chk(j);
      rd(A_STATUS, d);
      chk(d[3:0], 4'h1 << j);
      wait_cnt(i_link.frame_cnt + 1);
      chk(i_link.frame_cyc, (j == 2) ? 65 : (8 + ln) * 16);
      code_a = i_link.frame_bits[43:0] & ((44'h1 << ln) - 44'h1);
      @(posedge clk_in);
      #1;
      o1 = osc_out_or_lamp_pin_out;
      @(posedge clk_in);
      #1;
      if (opt[4]) begin
        chk({osc_out_or_lamp_pin_out, rf_power_or_lamp_pin_out}, 2'h1);
      end else begin
        chk(o1 ^ osc_out_or_lamp_pin_out, 1);
      end
      chk(tx_out, opt[0]);
      if (j != 2) begin
        chk(i_link.frame_n, 8 + ln);
        chk((i_link.frame_bits >> ln) & 64'hFF, cfg[3]);
        wait_cnt(i_link.frame_cnt + 1);
        code_b = i_link.frame_bits[43:0] & ((44'h1 << ln) - 44'h1);
        chk(code_a != code_b, 1);
      end
      @(posedge clk_in);
      i_link.release_key(j);
      repeat (1200) @(posedge clk_in);
      chk({key_pressed_out, tx_out}, {4'h0, opt[0]});
    end
    // Hold limit: continuous press ends in halt with RF stage off
    wr(A_OPTIONS, 8'h34);
    press_chk(0);
    d = 8'h00;
    for (int i = 0; i < 400 && d[6:4] != 3'h4; i++) rd(A_STATUS, d);
    chk(d[6:4], 3'h4);
    repeat (3) @(posedge clk_in);
    chk({rf_power_or_lamp_pin_out, tx_out}, 2'h2);
    i_link.release_key(0);
    repeat (3*SC+5) @(posedge clk_in);
    rd(A_STATUS, d);
    chk(d, 8'h00);
    // Lock, then every write must bounce off
    wr(A_LOCK, 8'h80);
    wr(A_SYNC, ~cfg[3]);
    wr(A_LOCK, 8'h00);
    // Nine frames were started: two per mode, one in the halt run
    rd(A_ROLL, d);
    chk(d, 8'h09);
    cfg[14] = d;
    check_map();
    give_verdict();
  end
endmodule
